/* bench/idb_irq_sink.sv */
`timescale 1ns/100ps
`default_nettype none
// Controller input stage: counts rising requests, so a held level counts once.
module idb_irq_sink
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Request line.
   input wire logic irq_line,
   // Requests seen.
   output logic [7:0] rise_cnt
);
   logic seen_reg;
   // Ready straight out of reset, before any source is set up.
   always_ff @(posedge clock)
   begin
      seen_reg <= irq_line & ~sys_rst;
      if (sys_rst)
         rise_cnt <= 8'h00;
      else if (irq_line && !seen_reg)
         rise_cnt <= rise_cnt + 8'h01;
   end
endmodule : idb_irq_sink
`default_nettype wire

/* bench/test_idb_doorbell.sv */
`timescale 1ns/100ps
`default_nettype none
module test_idb_doorbell import idb_pkg::*;;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic irq_out;
   logic [7:0] rise_cnt;
   logic [31:0] pend = 32'h0;
   logic [31:0] msk = 32'h0;
   logic last = 1'b0;
   logic [7:0] cmds [4] = '{IDB_OFS_SET, IDB_OFS_CLEAR, IDB_OFS_ENABLE, IDB_OFS_DISABLE};
   int error_cnt = 0;
   int checks = 0;
   int rises = 0;
   // Clock runs from time zero, so every access finds it enabled.
   initial
   begin
      forever #50 clock = ~clock;
   end
   idb_doorbell idb_doorbell_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));
   idb_irq_sink idb_irq_sink_i (.clock(clock), .sys_rst(sys_rst), .irq_line(irq_out), .rise_cnt(rise_cnt));
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task tally_and_finish;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   // Write one command, update the model, then compare the line one cycle on.
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (a == IDB_OFS_SET) pend = pend | d;
      if (a == IDB_OFS_CLEAR) pend = pend & ~d;
      if (a == IDB_OFS_ENABLE) msk = msk | d;
      if (a == IDB_OFS_DISABLE) msk = msk & ~d;
      if (!last && (pend & msk) != 0) rises++;
      last = (pend & msk) != 0;
      #1;
      check("irq_out", {31'h0, last}, {31'h0, irq_out});
   endtask : wr
   // Read one offset; the model answers zero for commands and holes.
   task rd(input logic [7:0] a);
      logic [31:0] e;
      e = (a == IDB_OFS_PENDING) ? pend : (a == IDB_OFS_MASK) ? msk : (a == IDB_OFS_STATUS) ? pend & msk : 32'h0;
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", e, reg_rdata);
   endtask : rd
   task sweep;
      for (int o = 0; o < 32; o += 4) rd(8'(o));
      rd(8'hfc);
   endtask : sweep
   // Watchdog so that a hang still reaches the verdict.
   initial
   begin
      repeat (30000) @(posedge clock);
      error_cnt++;
      tally_and_finish();
   end
   initial
   begin
      void'($urandom(32'ha4170ea2));
      for (int r = 0; r < 2; r++)
      begin
         sys_rst <= 1'b1;
         repeat (4) @(posedge clock);
         sys_rst <= 1'b0;
         pend = 32'h0;
         msk = 32'h0;
         last = 1'b0;
         rises = 0;
         sweep();
         for (int i = 0; i < 32; i++)
         begin
            wr(IDB_OFS_ENABLE, 32'h1 << i);
            wr(IDB_OFS_SET, 32'h1 << i);
            rd(IDB_OFS_STATUS);
            wr(IDB_OFS_DISABLE, 32'h1 << i);
         end
         sweep();
         for (int i = 0; i < 60; i++)
         begin
            wr(cmds[$urandom_range(3)], $urandom());
            sweep();
         end
         check("rise_cnt", 32'(rises & 255), {24'h0, rise_cnt});
      end
      tally_and_finish();
   end
endmodule : test_idb_doorbell
`default_nettype wire

/* inc/idb_pkg.sv */
// Notes on behaviour
// - Thirty-two sources, each with pending and mask.
// - Output high when any source pending and enabled.
// - Set command writes ones into pending bits.
// - Clear command writes ones clear pending bits.
// - Pending register readable, resets to zero.
// - Enable command sets mask bits written one.
// - Disable command clears mask bits written one.
// - Mask register readable, resets to zero.
// - Status reads pending AND mask.
// - Each source independent of all others.
// - Status bit one exactly when driving output.
package idb_pkg;
   localparam int unsigned IDB_SOURCES = 32;
   localparam int unsigned IDB_ADDR_W = 8;
   localparam logic [7:0] IDB_OFS_SET = 8'h00;
   localparam logic [7:0] IDB_OFS_CLEAR = 8'h04;
   localparam logic [7:0] IDB_OFS_PENDING = 8'h08;
   localparam logic [7:0] IDB_OFS_ENABLE = 8'h0c;
   localparam logic [7:0] IDB_OFS_DISABLE = 8'h10;
   localparam logic [7:0] IDB_OFS_MASK = 8'h14;
   localparam logic [7:0] IDB_OFS_STATUS = 8'h18;
   localparam logic [31:0] IDB_PENDING_RST = 32'h0000_0000;
   localparam logic [31:0] IDB_MASK_RST = 32'h0000_0000;
endpackage : idb_pkg

/* logic/idb_doorbell.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Doorbell interrupt block: 32 software sources ORed onto one line.
module idb_doorbell
   import idb_pkg::*;
#(
   parameter int unsigned SOURCES = IDB_SOURCES
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Register port.
   input wire logic [IDB_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Interrupt line.
   output logic irq_out
);
   typedef struct packed {
      logic [31:0] rdata;
      logic irq;
   } idb_top_state_t;

   idb_top_state_t st_reg;
   idb_top_state_t st_next;
   logic [SOURCES-1:0] pend;
   logic [SOURCES-1:0] mask;
   logic [SOURCES-1:0] set_v;
   logic [SOURCES-1:0] clr_v;
   logic [SOURCES-1:0] en_v;
   logic [SOURCES-1:0] dis_v;
   logic [SOURCES-1:0] pend_nx;
   logic [SOURCES-1:0] mask_nx;
   logic [31:0] pend_w;
   logic [31:0] mask_w;

   // Decode writes into per-source command vectors.
   always_comb
   begin
      set_v = '0;
      clr_v = '0;
      en_v = '0;
      dis_v = '0;
      if (reg_wr && reg_addr == IDB_OFS_SET)
      begin
         set_v = reg_wdata[SOURCES-1:0];
      end
      else if (reg_wr && reg_addr == IDB_OFS_CLEAR)
      begin
         clr_v = reg_wdata[SOURCES-1:0];
      end
      else if (reg_wr && reg_addr == IDB_OFS_ENABLE)
      begin
         en_v = reg_wdata[SOURCES-1:0];
      end
      else if (reg_wr && reg_addr == IDB_OFS_DISABLE)
      begin
         dis_v = reg_wdata[SOURCES-1:0];
      end
   end

   // Each source is its own cell, so no source can disturb another.
   genvar gi;
   generate
      for (gi = 0; gi < SOURCES; gi++)
      begin : g_src
         idb_source_bit u_bit (
            .clock(clock),
            .sys_rst(sys_rst),
            .set_cmd(set_v[gi]),
            .clear_cmd(clr_v[gi]),
            .enable_cmd(en_v[gi]),
            .disable_cmd(dis_v[gi]),
            .pending(pend[gi]),
            .mask(mask[gi])
         );
         // Next values mirror the cell so the output flop lands with it.
         assign pend_nx[gi] = !clr_v[gi] && (set_v[gi] || pend[gi]);
         assign mask_nx[gi] = !dis_v[gi] && (en_v[gi] || mask[gi]);
      end
   endgenerate

   assign pend_w = 32'(pend);
   assign mask_w = 32'(mask);

   // The interrupt flop is fed by next state, so it changes in the same
   // edge as the pending and mask bits and never lags them.
   always_comb
   begin
      st_next = st_reg;
      st_next.irq = |(pend_nx & mask_nx);
      st_next.rdata = 32'h0000_0000;
      if (reg_rd && reg_addr == IDB_OFS_PENDING)
      begin
         st_next.rdata = pend_w;
      end
      else if (reg_rd && reg_addr == IDB_OFS_MASK)
      begin
         st_next.rdata = mask_w;
      end
      else if (reg_rd && reg_addr == IDB_OFS_STATUS)
      begin
         st_next.rdata = pend_w & mask_w;
      end
      // Command offsets and unmapped offsets read zero with no effect.
   end

   // Output and read-data register.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign irq_out = st_reg.irq;

   a_irq_tracks: assert property (@(posedge clock) disable iff (sys_rst) irq_out == |(pend & mask))
      else $error("Interrupt line disagrees with pending and mask.");
   a_status_read: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == IDB_OFS_STATUS |=> reg_rdata == 32'($past(pend) & $past(mask)))
      else $error("Status read is not pending AND mask.");
   a_cmd_reads_zero: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && (reg_addr == IDB_OFS_SET || reg_addr == IDB_OFS_CLEAR || reg_addr == IDB_OFS_ENABLE
      || reg_addr == IDB_OFS_DISABLE) |=> reg_rdata == 32'h0000_0000)
      else $error("Command register read was not zero.");
   a_read_no_effect: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd |=> pend == $past(pend) && mask == $past(mask))
      else $error("A read changed pending or mask.");
   a_set_irq: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && reg_addr == IDB_OFS_SET && |(reg_wdata[SOURCES-1:0] & mask) |=> irq_out)
      else $error("Set of an enabled source did not raise the line.");
endmodule : idb_doorbell
`default_nettype wire

/* logic/idb_source_bit.sv */
`timescale 1ns/100ps
`default_nettype none
// One doorbell source: a pending flop and a mask flop.
module idb_source_bit
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Command strobes for this source.
   input wire logic set_cmd,
   input wire logic clear_cmd,
   input wire logic enable_cmd,
   input wire logic disable_cmd,
   // State.
   output logic pending,
   output logic mask
);
   import idb_pkg::*;

   typedef struct packed {
      logic pending;
      logic mask;
   } idb_bit_state_t;

   idb_bit_state_t st_reg;
   idb_bit_state_t st_next;

   // Clear and disable are applied last so they win a same-cycle conflict.
   always_comb
   begin
      st_next = st_reg;
      if (set_cmd)
      begin
         st_next.pending = 1'b1;
      end
      if (clear_cmd)
      begin
         st_next.pending = 1'b0;
      end
      if (enable_cmd)
      begin
         st_next.mask = 1'b1;
      end
      if (disable_cmd)
      begin
         st_next.mask = 1'b0;
      end
   end

   // Both flags reset cleared.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_reg <= '{pending: IDB_PENDING_RST[0], mask: IDB_MASK_RST[0]};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign pending = st_reg.pending;
   assign mask = st_reg.mask;

   // A clear always beats a simultaneous set.
   a_clear_wins: assert property (@(posedge clock) disable iff (sys_rst) clear_cmd |=> !pending)
      else $error("Pending bit survived a clear command.");
   a_disable_wins: assert property (@(posedge clock) disable iff (sys_rst) disable_cmd |=> !mask)
      else $error("Mask bit survived a disable command.");
   a_set_takes: assert property (@(posedge clock) disable iff (sys_rst) set_cmd && !clear_cmd |=> pending)
      else $error("Set command did not pend the source.");
   a_enable_takes: assert property (@(posedge clock) disable iff (sys_rst)
      enable_cmd && !disable_cmd |=> mask)
      else $error("Enable command did not set the mask.");
endmodule : idb_source_bit
`default_nettype wire
